// file: rtl/link_security_packet_cmds.sv
// Command interpreter for packet-type, authentication and encryption commands.
// Notes on behaviour
// [R1] Voice link packet mask: HV1 0x0020, HV2 0x0040, HV3 0x0080; others reserved.
// [R2] Accepted packet-type command answers at once with a command status event.
// [R3] Packet-type-changed event goes to the local host only, after manager reports.
// [R4] Packet-type command never yields command complete; changed event ends it.
// [R5] Authentication command code 0x0011, one parameter: connection handle.
// [R6] Host must not request authentication on an encrypted link.
// [R7] Failed authentication keeps the link up; host decides on disconnect.
// [R8] Handle is 12 bits; 0x0000-0x0EFF valid, 0x0F00-0x0FFF reserved.
// [R9] Authentication covers every handle sharing the given handle's endpoint.
// [R10] Authentication gives command status, then authentication complete only.
// [R11] Missing link key: ask the host first, before authentication complete.
// [R12] Authentication and encryption handles should name data, not voice, links.
// [R13] Encryption command code 0x0013: handle then one-byte enable flag.
// [R14] Enable byte 0x00 turns encryption off, 0x01 turns it on.
// [R15] Encryption change applies to every handle sharing the endpoint.
// [R16] Data traffic halts on all endpoint handles while encryption changes.
// [R17] Encryption command: status on receipt, change event after manager finishes.
// [R18] Encryption command never yields command complete; change event ends it.
// [R19] Every event is emitted only when the host event mask allows it.
// [R20] Packet mask is an OR of types; at least one set; only those used.
module link_security_packet_cmds #(
    parameter int ENTRIES = 8,
    parameter int IDX_W = 3,
    parameter int EP_W = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [9:0] cmd_ocf,
    input wire logic [11:0] cmd_handle,
    input wire logic [15:0] cmd_pkt_type,
    input wire logic [7:0] cmd_enc_enable,
    input wire logic [4:0] event_mask,
    input wire logic tbl_wr,
    input wire logic [IDX_W-1:0] tbl_idx,
    input wire logic [EP_W-1:0] tbl_ep,
    input wire logic tbl_sco,
    input wire logic lm_done,
    input wire logic lm_fail,
    input wire logic key_present,
    input wire logic key_supplied,
    output logic cmd_ready,
    output logic evt_valid,
    output logic [2:0] evt_code,
    output logic [7:0] evt_status,
    output logic [11:0] evt_handle,
    output logic lm_start,
    output logic [9:0] lm_op,
    output logic [15:0] lm_pkt_type,
    output logic lm_enc_on,
    output logic [EP_W-1:0] lm_ep,
    output logic [ENTRIES-1:0] acl_halt,
    output logic [ENTRIES-1:0] enc_state,
    output logic [ENTRIES-1:0] auth_state
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_LOOK = 3'b001,
        S_CHECK = 3'b010,
        S_KEYREQ = 3'b011,
        S_WAIT_KEY = 3'b100,
        S_RUN = 3'b101,
        S_WAIT_LM = 3'b110
    } state_e;

    state_e state_ff;
    logic [9:0] op_ff;
    logic [11:0] handle_ff;
    logic [15:0] pkt_ff;
    logic enc_req_ff;
    logic [EP_W-1:0] rd_ep;
    logic rd_sco;
    logic rd_valid;
    logic [EP_W-1:0] ep_of [ENTRIES];
    logic [ENTRIES-1:0] same_ep;

    // A handle is legal only below the reserved range and inside the table.
    function automatic logic handle_ok(input logic [11:0] h);
        return (h <= link_cmd_pkg::HANDLE_MAX) && (h < 12'(ENTRIES)); // [R8]
    endfunction

    function automatic logic evt_on(input logic [4:0] m, input logic [2:0] c);
        return m[c]; // [R19]
    endfunction

    conn_table #(
        .ENTRIES(ENTRIES),
        .IDX_W(IDX_W),
        .EP_W(EP_W)
    ) u_table (
        .clock(clock),
        .rst(rst),
        .wr_en(tbl_wr),
        .wr_idx(tbl_idx),
        .wr_ep(tbl_ep),
        .wr_sco(tbl_sco),
        .rd_idx(handle_ff[IDX_W-1:0]),
        .rd_ep(rd_ep),
        .rd_sco(rd_sco),
        .rd_valid(rd_valid)
    );

    // Shadow copy of endpoints lets the whole group be matched in one cycle.
    always_ff @(posedge clock) begin
        if (tbl_wr) begin
            ep_of[tbl_idx] <= tbl_ep;
        end
    end

    always_comb begin
        for (int i = 0; i < ENTRIES; i++) begin
            same_ep[i] = (ep_of[i] == lm_ep); // [R9] [R15]
        end
    end

    // Parameter checks; the controller refuses what the host must not send.
    logic param_bad;
    always_comb begin
        param_bad = !rd_valid;
        if (op_ff == link_cmd_pkg::OCF_CHG_PKT) begin
            if (rd_sco) begin
                param_bad = param_bad
                    || ((pkt_ff & ~link_cmd_pkg::PKT_SCO_ALLOWED) != '0) // [R1]
                    || ((pkt_ff & link_cmd_pkg::PKT_SCO_ALLOWED) == '0); // [R20]
            end else begin
                param_bad = param_bad || (pkt_ff == '0); // [R20]
            end
        end else begin
            param_bad = param_bad || rd_sco; // [R12]
            if (op_ff == link_cmd_pkg::OCF_AUTH) begin
                param_bad = param_bad
                    || enc_state[handle_ff[IDX_W-1:0]]; // [R6]
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= S_IDLE;
            op_ff <= '0;
            handle_ff <= '0;
            pkt_ff <= '0;
            enc_req_ff <= 1'b0;
            cmd_ready <= 1'b0;
            evt_valid <= 1'b0;
            evt_code <= '0;
            evt_status <= '0;
            evt_handle <= '0;
            lm_start <= 1'b0;
            lm_op <= '0;
            lm_pkt_type <= '0;
            lm_enc_on <= 1'b0;
            lm_ep <= '0;
        end else begin
            evt_valid <= 1'b0;
            lm_start <= 1'b0;
            cmd_ready <= (state_ff == S_IDLE) && !(cmd_valid && cmd_ready);
            unique case (state_ff)
                S_IDLE: begin
                    if (cmd_valid && cmd_ready) begin
                        op_ff <= cmd_ocf;
                        handle_ff <= cmd_handle;
                        pkt_ff <= cmd_pkt_type;
                        enc_req_ff <= (cmd_enc_enable == link_cmd_pkg::ENC_ON);
                        cmd_ready <= 1'b0;
                        if (cmd_ocf != link_cmd_pkg::OCF_CHG_PKT
                            && cmd_ocf != link_cmd_pkg::OCF_AUTH // [R5]
                            && cmd_ocf != link_cmd_pkg::OCF_SET_ENC) begin // [R13]
                            evt_valid <= evt_on(event_mask,
                                link_cmd_pkg::EVT_CMD_STATUS); // [R19]
                            evt_code <= link_cmd_pkg::EVT_CMD_STATUS;
                            evt_status <= link_cmd_pkg::ST_BAD_CMD;
                            evt_handle <= cmd_handle;
                            state_ff <= S_IDLE;
                        end else if (!handle_ok(cmd_handle)
                            || (cmd_ocf == link_cmd_pkg::OCF_SET_ENC
                            && cmd_enc_enable != link_cmd_pkg::ENC_ON
                            && cmd_enc_enable != link_cmd_pkg::ENC_OFF)) begin // [R14]
                            evt_valid <= evt_on(event_mask,
                                link_cmd_pkg::EVT_CMD_STATUS);
                            evt_code <= link_cmd_pkg::EVT_CMD_STATUS;
                            evt_status <= link_cmd_pkg::ST_BAD_PARAM; // [R8]
                            evt_handle <= cmd_handle;
                        end else begin
                            state_ff <= S_LOOK;
                        end
                    end
                end
                S_LOOK: begin
                    state_ff <= S_CHECK;
                end
                S_CHECK: begin
                    evt_valid <= evt_on(event_mask,
                        link_cmd_pkg::EVT_CMD_STATUS); // [R2] [R10] [R17]
                    evt_code <= link_cmd_pkg::EVT_CMD_STATUS;
                    evt_handle <= handle_ff;
                    lm_ep <= rd_ep;
                    if (param_bad) begin
                        evt_status <= link_cmd_pkg::ST_BAD_PARAM;
                        state_ff <= S_IDLE;
                    end else begin
                        evt_status <= link_cmd_pkg::ST_OK;
                        if (op_ff == link_cmd_pkg::OCF_AUTH && !key_present) begin
                            state_ff <= S_KEYREQ; // [R11]
                        end else begin
                            state_ff <= S_RUN;
                        end
                    end
                end
                S_KEYREQ: begin
                    // Status event went out last cycle; key request follows.
                    evt_valid <= evt_on(event_mask,
                        link_cmd_pkg::EVT_KEY_REQ); // [R11]
                    evt_code <= link_cmd_pkg::EVT_KEY_REQ;
                    evt_status <= link_cmd_pkg::ST_OK;
                    state_ff <= S_WAIT_KEY;
                end
                S_WAIT_KEY: begin
                    if (key_supplied) begin
                        state_ff <= S_RUN;
                    end
                end
                S_RUN: begin
                    lm_start <= 1'b1;
                    lm_op <= op_ff;
                    lm_pkt_type <= pkt_ff; // [R20]
                    lm_enc_on <= enc_req_ff;
                    state_ff <= S_WAIT_LM;
                end
                S_WAIT_LM: begin
                    if (lm_done) begin
                        // Only the completion event ends a command here. [R4] [R18]
                        evt_handle <= handle_ff;
                        evt_status <= lm_fail ? link_cmd_pkg::ST_BUSY
                                              : link_cmd_pkg::ST_OK;
                        state_ff <= S_IDLE;
                        unique case (op_ff)
                            link_cmd_pkg::OCF_CHG_PKT: begin
                                evt_code <= link_cmd_pkg::EVT_PKT_CHANGED; // [R3]
                                evt_valid <= evt_on(event_mask,
                                    link_cmd_pkg::EVT_PKT_CHANGED);
                            end
                            link_cmd_pkg::OCF_AUTH: begin
                                evt_code <= link_cmd_pkg::EVT_AUTH_DONE; // [R10]
                                evt_valid <= evt_on(event_mask,
                                    link_cmd_pkg::EVT_AUTH_DONE);
                            end
                            default: begin
                                evt_code <= link_cmd_pkg::EVT_ENC_CHANGE; // [R17]
                                evt_valid <= evt_on(event_mask,
                                    link_cmd_pkg::EVT_ENC_CHANGE);
                            end
                        endcase
                    end
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    // Data traffic on the endpoint group stops while encryption changes.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acl_halt <= '0;
        end else if (state_ff == S_RUN && op_ff == link_cmd_pkg::OCF_SET_ENC) begin
            acl_halt <= same_ep; // [R16]
        end else if (state_ff == S_WAIT_LM && lm_done) begin
            acl_halt <= '0;
        end
    end

    // Link state per handle; a failed authentication drops nothing.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            enc_state <= '0;
            auth_state <= '0;
        end else if (state_ff == S_WAIT_LM && lm_done && !lm_fail) begin
            if (op_ff == link_cmd_pkg::OCF_SET_ENC) begin
                for (int i = 0; i < ENTRIES; i++) begin
                    if (same_ep[i]) begin
                        enc_state[i] <= enc_req_ff; // [R15]
                    end
                end
            end else if (op_ff == link_cmd_pkg::OCF_AUTH) begin
                auth_state <= auth_state | same_ep; // [R9] [R7]
            end
        end
    end
endmodule // link_security_packet_cmds

// file: pkg/link_cmd_pkg.sv
// Constants shared by the link-control command interpreter.
package link_cmd_pkg;
    localparam logic [9:0] OCF_CHG_PKT = 10'h00f;
    localparam logic [9:0] OCF_AUTH = 10'h011;
    localparam logic [9:0] OCF_SET_ENC = 10'h013;
    localparam logic [15:0] PKT_HV1 = 16'h0020;
    localparam logic [15:0] PKT_HV2 = 16'h0040;
    localparam logic [15:0] PKT_HV3 = 16'h0080;
    localparam logic [15:0] PKT_SCO_ALLOWED = 16'h00e0;
    localparam logic [11:0] HANDLE_MAX = 12'h eff;
    localparam logic [7:0] ENC_OFF = 8'h00;
    localparam logic [7:0] ENC_ON = 8'h01;
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_BAD_PARAM = 8'h12;
    localparam logic [7:0] ST_BAD_CMD = 8'h01;
    localparam logic [7:0] ST_BUSY = 8'h0c;
    localparam logic [2:0] EVT_CMD_STATUS = 3'h0;
    localparam logic [2:0] EVT_PKT_CHANGED = 3'h1;
    localparam logic [2:0] EVT_AUTH_DONE = 3'h2;
    localparam logic [2:0] EVT_ENC_CHANGE = 3'h3;
    localparam logic [2:0] EVT_KEY_REQ = 3'h4;
    localparam int EVT_MASK_W = 5;
    localparam logic [EVT_MASK_W-1:0] EVT_MASK_RST = 5'h1f;
endpackage

// file: rtl/conn_table.sv
// Small per-connection memory: endpoint, link type and valid flag.
module conn_table #(
    parameter int ENTRIES = 8,
    parameter int IDX_W = 3,
    parameter int EP_W = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [IDX_W-1:0] wr_idx,
    input wire logic [EP_W-1:0] wr_ep,
    input wire logic wr_sco,
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [EP_W-1:0] rd_ep,
    output logic rd_sco,
    output logic rd_valid
);
    logic [EP_W-1:0] ep_mem [ENTRIES];
    logic [ENTRIES-1:0] sco_ff;
    logic [ENTRIES-1:0] valid_ff;

    always_ff @(posedge clock) begin
        if (wr_en) begin
            ep_mem[wr_idx] <= wr_ep;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sco_ff <= '0;
            valid_ff <= '0;
        end else if (wr_en) begin
            sco_ff[wr_idx] <= wr_sco;
            valid_ff[wr_idx] <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_ep <= '0;
            rd_sco <= 1'b0;
            rd_valid <= 1'b0;
        end else begin
            rd_ep <= ep_mem[rd_idx];
            rd_sco <= sco_ff[rd_idx];
            rd_valid <= valid_ff[rd_idx];
        end
    end
endmodule // conn_table

// file: bench/link_security_packet_cmds_properties.sv
// Concurrent checks on the command interpreter's ports.
module link_cmds_checker #(
    parameter int ENTRIES = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [4:0] event_mask,
    input wire logic lm_done,
    input wire logic lm_fail,
    input wire logic evt_valid,
    input wire logic [2:0] evt_code,
    input wire logic lm_start,
    input wire logic [9:0] lm_op,
    input wire logic [15:0] lm_pkt_type,
    input wire logic [ENTRIES-1:0] acl_halt,
    input wire logic [ENTRIES-1:0] auth_state
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    chk_ready_drops: assert property (
        cmd_valid && cmd_ready |=> !cmd_ready)
        else $error("ready stayed high after a command was taken");
    chk_status_first: assert property (
        cmd_valid && cmd_ready && event_mask[0]
        |-> ##[1:3] evt_valid && evt_code == link_cmd_pkg::EVT_CMD_STATUS)
        else $error("no command status after a command");
    chk_no_complete: assert property (
        evt_valid |-> evt_code <= 3'h4)
        else $error("unexpected event code");
    chk_mask_gate: assert property (
        evt_valid |-> event_mask[evt_code])
        else $error("masked event was emitted");
    chk_enc_event: assert property (
        lm_done && !lm_fail && event_mask[3]
        && lm_op == link_cmd_pkg::OCF_SET_ENC
        |=> evt_valid && evt_code == link_cmd_pkg::EVT_ENC_CHANGE)
        else $error("encryption change event missing");
    chk_halt_span: assert property (
        lm_done && lm_op == link_cmd_pkg::OCF_SET_ENC
        |-> acl_halt != '0 ##1 acl_halt == '0)
        else $error("data traffic halt not held until finish");
    chk_fail_keeps: assert property (
        lm_done && lm_fail
        && lm_op == link_cmd_pkg::OCF_AUTH |=> $stable(auth_state))
        else $error("failed authentication changed link state");
    chk_auth_event: assert property (
        lm_done && event_mask[2]
        && lm_op == link_cmd_pkg::OCF_AUTH
        |=> evt_valid && evt_code == link_cmd_pkg::EVT_AUTH_DONE)
        else $error("authentication complete event missing");
    chk_pkt_nonzero: assert property (
        lm_start
        && lm_op == link_cmd_pkg::OCF_CHG_PKT |-> lm_pkt_type != 16'h0000)
        else $error("empty packet type mask sent to manager");
    chk_key_first: assert property (
        evt_valid
        && evt_code == link_cmd_pkg::EVT_KEY_REQ |=> !lm_start)
        else $error("manager started before key was supplied");
endmodule // link_cmds_checker
bind link_security_packet_cmds link_cmds_checker #(.ENTRIES(ENTRIES)) chk_i (
    .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .event_mask(event_mask), .lm_done(lm_done), .lm_fail(lm_fail),
    .evt_valid(evt_valid), .evt_code(evt_code), .lm_start(lm_start),
    .lm_op(lm_op), .lm_pkt_type(lm_pkt_type), .acl_halt(acl_halt),
    .auth_state(auth_state));

// file: bench/lm_partner.sv
// Link manager and host key responder facing the interpreter.
module lm_partner (
    input wire logic clock,
    input wire logic lm_start,
    input wire logic evt_valid,
    input wire logic [2:0] evt_code,
    input wire logic fail_in,
    input wire logic [7:0] dly,
    output logic lm_done,
    output logic lm_fail,
    output logic key_supplied
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        lm_done = 1'b0;
        lm_fail = 1'b1;
        key_supplied = 1'b0;
    end
    // The failure flag is inverted outside the done pulse so nothing leans on it.
    always begin
        @(negedge clock iff lm_start);
        repeat (dly + 1) @(posedge clock);
        #1 lm_done = 1'b1;
        lm_fail = fail_in;
        @(posedge clock);
        #1 lm_done = 1'b0;
        lm_fail = ~fail_in;
    end
    always begin
        @(negedge clock iff evt_valid && evt_code == link_cmd_pkg::EVT_KEY_REQ);
        repeat (2) @(posedge clock);
        #1 key_supplied = 1'b1;
        @(posedge clock);
        #1 key_supplied = 1'b0;
    end
endmodule // lm_partner

// file: bench/link_security_packet_cmds_tb.sv
// Self-checking bench for the command interpreter.
module link_security_packet_cmds_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst, cmd_valid, tbl_wr, tbl_sco, lm_done, lm_fail;
    logic key_present, key_supplied, cmd_ready, evt_valid, lm_start, lm_enc_on;
    logic fail_in;
    logic [9:0] cmd_ocf, lm_op;
    logic [11:0] cmd_handle, evt_handle;
    logic [15:0] cmd_pkt_type, lm_pkt_type;
    logic [7:0] cmd_enc_enable, evt_status, dly, enc_m, auth_m;
    logic [4:0] event_mask;
    logic [2:0] tbl_idx, evt_code;
    logic [3:0] tbl_ep, lm_ep;
    logic [7:0] acl_halt, enc_state, auth_state;
    logic [3:0] ep_m[8] = '{4'h1, 4'h1, 4'h2, 4'h3, 4'h2, 4'h5, 4'h6, 4'h7};
    logic [15:0] pkts[6] = '{16'h0020, 16'h0040, 16'h0080, 16'h00e0,
        16'h0100, 16'h0000};
    logic [10:0] want_q[$];
    int fail_count = 0, cmp_count = 0;
    int seed = 32'h8c28b798;
    link_security_packet_cmds #(.ENTRIES(8), .IDX_W(3), .EP_W(4)) uut (
        .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_ocf(cmd_ocf),
        .cmd_handle(cmd_handle), .cmd_pkt_type(cmd_pkt_type),
        .cmd_enc_enable(cmd_enc_enable), .event_mask(event_mask),
        .tbl_wr(tbl_wr), .tbl_idx(tbl_idx), .tbl_ep(tbl_ep), .tbl_sco(tbl_sco),
        .lm_done(lm_done), .lm_fail(lm_fail), .key_present(key_present),
        .key_supplied(key_supplied), .cmd_ready(cmd_ready),
        .evt_valid(evt_valid), .evt_code(evt_code), .evt_status(evt_status),
        .evt_handle(evt_handle), .lm_start(lm_start), .lm_op(lm_op),
        .lm_pkt_type(lm_pkt_type), .lm_enc_on(lm_enc_on), .lm_ep(lm_ep),
        .acl_halt(acl_halt), .enc_state(enc_state), .auth_state(auth_state));
    lm_partner lm_i (.clock(clock), .lm_start(lm_start), .evt_valid(evt_valid),
        .evt_code(evt_code), .fail_in(fail_in), .dly(dly), .lm_done(lm_done),
        .lm_fail(lm_fail), .key_supplied(key_supplied));
    always #5 clock = ~clock;
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    task automatic want(input logic [2:0] c, input logic [7:0] s);
        if (event_mask[c]) want_q.push_back({c, s});
    endtask
    // Runs one command, predicting its events and the table state after it.
    task automatic run(input logic [9:0] o, input logic [11:0] h,
        input logic [15:0] pt, input logic [7:0] en, input logic fl);
        int n;
        logic sc;
        logic [10:0] e;
        logic [7:0] g;
        sc = (h == 12'h003);
        foreach (g[j]) g[j] = (ep_m[j] == ep_m[h[2:0]]);
        want_q = {};
        if (!(o inside {link_cmd_pkg::OCF_CHG_PKT, link_cmd_pkg::OCF_AUTH,
            link_cmd_pkg::OCF_SET_ENC})) want(3'h0, link_cmd_pkg::ST_BAD_CMD);
        else if (h > 12'h007 || (o == link_cmd_pkg::OCF_SET_ENC && en > 1)
            || (o != link_cmd_pkg::OCF_CHG_PKT && sc)
            || (o == link_cmd_pkg::OCF_AUTH && enc_m[h[2:0]])
            || (o == link_cmd_pkg::OCF_CHG_PKT && (pt == 16'h0000
            || (pt & ~link_cmd_pkg::PKT_SCO_ALLOWED) != 16'h0000)))
            want(3'h0, link_cmd_pkg::ST_BAD_PARAM);
        else begin
            want(3'h0, link_cmd_pkg::ST_OK);
            if (o == link_cmd_pkg::OCF_AUTH && !key_present) want(3'h4, 8'h00);
            if (o == link_cmd_pkg::OCF_CHG_PKT) want(3'h1, link_cmd_pkg::ST_OK);
            if (o == link_cmd_pkg::OCF_SET_ENC) want(3'h3, link_cmd_pkg::ST_OK);
            if (o == link_cmd_pkg::OCF_AUTH)
                want(3'h2, fl ? link_cmd_pkg::ST_BUSY : link_cmd_pkg::ST_OK);
            for (int j = 0; j < 8; j++) begin
                if (ep_m[j] == ep_m[h[2:0]] && o == link_cmd_pkg::OCF_SET_ENC)
                    enc_m[j] = en[0];
                if (ep_m[j] == ep_m[h[2:0]] && o == link_cmd_pkg::OCF_AUTH && !fl)
                    auth_m[j] = 1'b1;
            end
        end
        fail_in = fl;
        dly = 8'($unsigned($random(seed)) % 6);
        while (cmd_ready !== 1'b1) @(posedge clock) #1;
        {cmd_valid, cmd_ocf, cmd_handle, cmd_pkt_type} = {1'b1, o, h, pt};
        cmd_enc_enable = en;
        @(posedge clock) #1 cmd_valid = 1'b0;
        for (n = 0; n < 200 && cmd_ready !== 1'b1; n++) begin
            if (evt_valid === 1'b1) begin
                e = (want_q.size() > 0) ? want_q.pop_front() : 11'h7ff;
                check(16'(evt_code), 16'(e[10:8]));
                if (e[10:8] != 3'h4) begin
                    check(16'(evt_status), 16'(e[7:0]));
                end
                if (e[10:8] inside {3'h1, 3'h2, 3'h3})
                    check(16'(evt_handle), 16'(h));
            end
            if (lm_start === 1'b1) begin
                check(16'(lm_op), 16'(o));
                check(lm_pkt_type, pt);
                check(16'(lm_enc_on), 16'(en[0]));
                check(16'(lm_ep), 16'(ep_m[h[2:0]]));
                check(16'(acl_halt),
                    16'(g & {8{o == link_cmd_pkg::OCF_SET_ENC}}));
            end
            @(posedge clock) #1;
        end
        check(16'(want_q.size()), 16'h0000);
        check(16'(enc_state), 16'(enc_m));
        check(16'(auth_state), 16'(auth_m));
        check(16'(acl_halt), 16'h0000);
    endtask
    initial begin
        #200us;
        fail_count++;
        test_done();
    end
    initial begin
        {clock, rst, cmd_valid, tbl_wr, tbl_sco, fail_in} = 6'b010000;
        {cmd_ocf, cmd_handle, cmd_pkt_type, cmd_enc_enable} = '0;
        {tbl_idx, tbl_ep, dly, enc_m, auth_m} = '0;
        event_mask = link_cmd_pkg::EVT_MASK_RST;
        key_present = 1'b1;
        repeat (12) @(posedge clock);
        #1 rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge clock) #1;
            {tbl_wr, tbl_idx, tbl_ep, tbl_sco} = {1'b1, 3'(i), ep_m[i], i == 3};
        end
        @(posedge clock) #1 tbl_wr = 1'b0;
        foreach (pkts[i])
            run(link_cmd_pkg::OCF_CHG_PKT, 12'h003, pkts[i], 0, 0);
        run(link_cmd_pkg::OCF_SET_ENC, 12'h000, 0, 8'h01, 0);
        run(link_cmd_pkg::OCF_AUTH, 12'h001, 0, 0, 0);
        run(link_cmd_pkg::OCF_SET_ENC, 12'h001, 0, 8'h02, 0);
        run(link_cmd_pkg::OCF_SET_ENC, 12'h001, 0, 8'h00, 0);
        key_present = 1'b0;
        run(link_cmd_pkg::OCF_AUTH, 12'h002, 0, 0, 1);
        key_present = 1'b1;
        run(link_cmd_pkg::OCF_AUTH, 12'h002, 0, 0, 0);
        run(10'h00e, 12'h000, 0, 0, 0);
        run(link_cmd_pkg::OCF_AUTH, 12'hf00, 0, 0, 0);
        run(link_cmd_pkg::OCF_AUTH, 12'h003, 0, 0, 0);
        event_mask = 5'h17;
        run(link_cmd_pkg::OCF_SET_ENC, 12'h005, 0, 8'h01, 0);
        event_mask = link_cmd_pkg::EVT_MASK_RST;
        repeat (6) run(link_cmd_pkg::OCF_SET_ENC,
            12'($unsigned($random(seed)) % 3),
            0, 8'($unsigned($random(seed)) % 2), 0);
        test_done();
    end
endmodule // link_security_packet_cmds_tb
